/* rtl/pasmt_pkg.sv */
// package of constants and types for the pipelined adc sample timing block
package pasmt_pkg;
  // ---------------------------------------------------------------------------
  // widths and defaults
  // ---------------------------------------------------------------------------
  localparam int unsigned PIPE_DEPTH_DEF  = 3;   // converter pipeline depth
  localparam int unsigned DATA_W_DEF      = 16;  // converted sample width
  localparam int unsigned CNT_W           = 32;  // sample and pulse counters
  localparam int unsigned PORT_W          = 8;   // digital port width
  localparam int unsigned NUM_PORTS       = 3;   // ports 0, 1 and 2
  localparam int unsigned RATE_DIV_DEF    = 4;   // clk cycles per max-rate period
  localparam int unsigned NONPIPE_PULSES  = 2;   // burst size without pipeline
  localparam int unsigned BUF_SIZE_NONE   = 0;   // buffer size that selects non-buffered

  // ---------------------------------------------------------------------------
  // acquisition modes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_FINITE     = 2'h0;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
  localparam logic [1:0] MODE_HW_SINGLE  = 2'h2;
  localparam logic [1:0] MODE_ON_DEMAND  = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FINITE,
    ST_BURST
  } pasmt_state_t;
endpackage

/* rtl/pasmt_delay_line.sv */
// delay line that ages converted samples by the pipeline depth
`timescale 1ns/1ns
`default_nettype none
module pasmt_delay_line
  import pasmt_pkg::*;
#(
  parameter int unsigned DEPTH  = PIPE_DEPTH_DEF,
  parameter int unsigned DATA_W = DATA_W_DEF
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_tick,
  input  wire logic [DATA_W-1:0] i_data,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_full
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] stage;
    logic [DEPTH-1:0]             fill;
  } pasmt_dl_t;

  pasmt_dl_t st_ff;
  pasmt_dl_t nxt_st;

  initial begin
    if (DEPTH < 1) $error("depth must be at least one");
  end

  // shift one stage per sample clock tick
  always_comb begin
    nxt_st = st_ff;
    if (i_tick) begin
      nxt_st.stage[0] = i_data;
      nxt_st.fill[0]  = 1'b1;
      for (int k = 1; k < int'(DEPTH); k++) begin
        nxt_st.stage[k] = st_ff.stage[k-1];
        nxt_st.fill[k]  = st_ff.fill[k-1];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_data = st_ff.stage[DEPTH-1];
  assign o_full = st_ff.fill[DEPTH-1];
endmodule
`default_nettype wire

/* rtl/pasmt_top.sv */
// sample clock timing for a pipelined converter: delay, flush, bursts, ao done, change detect
// Operation
// RULE1 - converted sample is readable only after pipeline-depth further sample ticks; on-demand bursts return the first pulse's word unaged
// RULE2 - finite acquisition of N samples receives N plus depth clock pulses
// RULE3 - internal clock generates the flush pulses itself without outside help
// RULE4 - external clock source must itself deliver the full flush pulse count
// RULE5 - on-demand read on pipelined converter emits depth plus one max-rate clocks
// RULE6 - on-demand read without pipeline emits exactly two sample clock pulses
// RULE7 - only the conversion of the first burst pulse is returned
// RULE8 - every burst pulse appears on the exported sample clock output
// RULE9 - clock source should keep sample rate at or above minimum rate
// RULE10 - long pause may corrupt pipelined samples; block neither flags nor drops them
// RULE11 - finite generation updates N samples, completion after pulse N plus one
// RULE12 - newer timing engine signals generation complete after pulse N
// RULE13 - shared-clock sync should use the output update clock as master
// RULE14 - change detection with buffer size zero reports changes directly, unbuffered
// RULE15 - first-port variant detects changes on port 0 only, ports 1-2 readable
// RULE16 - scope inputs accept only finite sample-clock acquisitions
// RULE17 - pipelined devices reject hardware-timed single-point input mode
// RULE18 - one fixed depth parameter drives data delay, flush and burst counts
`timescale 1ns/1ns
`default_nettype none
module pasmt_top
  import pasmt_pkg::*;
#(
  parameter int unsigned PIPE_DEPTH     = PIPE_DEPTH_DEF,
  parameter int unsigned DATA_W         = DATA_W_DEF,
  parameter int unsigned RATE_DIV       = RATE_DIV_DEF,
  parameter bit          PIPELINED      = 1'b1,
  parameter bit          SINGLE_OK      = 1'b0,
  parameter bit          NEW_ENGINE     = 1'b0,
  parameter bit          FIRST_PORT_ONLY = 1'b0
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  // acquisition request
  input  wire logic                            i_start,
  input  wire logic [1:0]                      i_mode,
  input  wire logic [CNT_W-1:0]                i_num_samples,
  input  wire logic                            i_use_internal_clk,
  input  wire logic                            i_scope_sel,
  input  wire logic                            i_ext_tick,
  input  wire logic [DATA_W-1:0]               i_adc_data,
  output logic                                 o_sample_clk,
  output logic                                 o_busy,
  output logic                                 o_reject,
  output logic [DATA_W-1:0]                    o_data,
  output logic                                 o_data_valid,
  output logic                                 o_acq_done,
  // analog output generation
  input  wire logic                            i_ao_start,
  input  wire logic [CNT_W-1:0]                i_ao_num_samples,
  input  wire logic                            i_output_update_clock,
  output logic                                 o_ao_update,
  output logic                                 o_ao_done,
  // digital change detection
  input  wire logic                            i_cd_enable,
  input  wire logic [CNT_W-1:0]                i_cd_buf_size,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] i_ports,
  output logic [NUM_PORTS-1:0][PORT_W-1:0]     o_cd_ports,
  output logic                                 o_cd_change
);
  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  initial begin
    if (PIPE_DEPTH < 1) $error("pipe depth must be at least one");
    if (RATE_DIV < 2) $error("rate divider must be at least two");
    if (DATA_W < 1) $error("data width must be at least one");
  end

  localparam logic [CNT_W-1:0] DEPTH_C  = CNT_W'(PIPE_DEPTH);           // RULE18
  localparam logic [CNT_W-1:0] BURST_C  = PIPELINED ? CNT_W'(PIPE_DEPTH + 1)
                                                    : CNT_W'(NONPIPE_PULSES);
  localparam logic [15:0]      DIV_LAST = 16'(RATE_DIV - 1);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    pasmt_state_t                  state;
    logic                          internal;
    logic [CNT_W-1:0]              req;
    logic [CNT_W-1:0]              pulses;
    logic [CNT_W-1:0]              kept;
    logic [15:0]                   div;
    logic                          sclk;
    logic                          tick_d;
    logic                          busy;
    logic                          reject;
    logic [DATA_W-1:0]             data;
    logic                          valid;
    logic                          done;
    logic                          ao_run;
    logic [CNT_W-1:0]              ao_cnt;
    logic [CNT_W-1:0]              ao_num;
    logic                          ao_upd;
    logic                          ao_done;
    logic [NUM_PORTS-1:0][PORT_W-1:0] cd_prev;
    logic [NUM_PORTS-1:0][PORT_W-1:0] cd_out;
    logic                          cd_chg;
  } pasmt_top_t;

  pasmt_top_t st_ff;
  pasmt_top_t nxt_st;

  logic              tick;
  logic [DATA_W-1:0] aged_data;
  logic              aged_full;

  // mode legality for the requested acquisition
  function automatic logic mode_illegal(input logic [1:0] mode, input logic scope);
    logic bad;
    bad = 1'b0;
    if (scope && mode != MODE_FINITE && mode != MODE_ON_DEMAND) bad = 1'b1;    // RULE16
    if (scope && mode == MODE_ON_DEMAND) bad = 1'b1;                          // RULE16
    if (PIPELINED && !SINGLE_OK && mode == MODE_HW_SINGLE) bad = 1'b1;        // RULE17
    return bad;
  endfunction

  // sample tick: internal max-rate divider or the outside clock source
  assign tick = st_ff.internal ? (st_ff.div == DIV_LAST) : i_ext_tick;        // RULE4

  // ---------------------------------------------------------------------------
  // pipeline ageing of converted data
  // ---------------------------------------------------------------------------
  // the converter word stands in the cycle after its tick, so the line shifts
  // on the delayed tick; shifting on the tick itself would capture a stale word.
  // the line is held clear while idle so that words left over from an earlier
  // acquisition or burst can never reach the output of the next one.
  pasmt_delay_line #(
    .DEPTH  (PIPE_DEPTH),
    .DATA_W (DATA_W)
  ) u_delay (
    .i_clk  (i_clk),
    .i_rst  (i_rst || st_ff.state == ST_IDLE),                                // RULE1
    .i_tick (st_ff.tick_d),                                                   // RULE1
    .i_data (i_adc_data),
    .o_data (aged_data),
    .o_full (aged_full)
  );

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.valid  = 1'b0;
    nxt_st.done   = 1'b0;
    nxt_st.reject = 1'b0;
    nxt_st.ao_upd = 1'b0;
    nxt_st.cd_chg = 1'b0;
    nxt_st.tick_d = tick && st_ff.state != ST_IDLE;
    // divider runs only while an internal-clock operation is active
    if (st_ff.state != ST_IDLE && st_ff.internal) begin
      nxt_st.div = (st_ff.div == DIV_LAST) ? 16'h0 : st_ff.div + 16'h1;
    end else begin
      nxt_st.div = 16'h0;
    end
    // exported clock rises once per max-rate period, in the cycle of the internal tick
    // when RATE_DIV is 3 or 4, and stays high for about half a max-rate period; one edge
    // per tick, so the exported pulse count equals the tick count exactly
    nxt_st.sclk = st_ff.internal ? (st_ff.state != ST_IDLE && st_ff.div >= 16'(RATE_DIV / 2))
                                 : (st_ff.state != ST_IDLE && i_ext_tick);    // RULE8
    unique case (st_ff.state)
      ST_IDLE: begin
        if (i_start) begin
          if (mode_illegal(i_mode, i_scope_sel) || i_mode == MODE_CONTINUOUS &&
              i_scope_sel) begin
            nxt_st.reject = 1'b1;
          end else if (i_mode == MODE_ON_DEMAND) begin
            nxt_st.state    = ST_BURST;
            nxt_st.internal = 1'b1;                                           // RULE5
            nxt_st.req      = BURST_C;                                        // RULE5 RULE6
            nxt_st.pulses   = '0;
            nxt_st.kept     = '0;
            nxt_st.busy     = 1'b1;
          end else if (i_mode == MODE_FINITE) begin
            nxt_st.state    = ST_FINITE;
            nxt_st.internal = i_use_internal_clk;
            nxt_st.req      = i_num_samples + DEPTH_C;                        // RULE2 RULE3
            nxt_st.pulses   = '0;
            nxt_st.kept     = '0;
            nxt_st.busy     = 1'b1;
          end else begin
            nxt_st.reject = 1'b1;
          end
        end
      end
      ST_FINITE: begin
        if (tick) begin
          nxt_st.pulses = st_ff.pulses + 1'b1;
        end
        // aged sample leaves the pipeline; pause damage is passed through
        if (st_ff.tick_d && aged_full && st_ff.kept < st_ff.req - DEPTH_C) begin // RULE1 RULE10
          nxt_st.data  = aged_data;
          nxt_st.valid = 1'b1;
          nxt_st.kept  = st_ff.kept + 1'b1;
        end
        // finish only after the word of the last tick has been taken
        if (st_ff.pulses == st_ff.req && !st_ff.tick_d) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy  = 1'b0;
          nxt_st.done  = 1'b1;
        end
      end
      ST_BURST: begin
        if (tick) begin
          nxt_st.pulses = st_ff.pulses + 1'b1;
        end
        // keep only the sample of the first pulse, drop the rest
        if (st_ff.tick_d && st_ff.kept == '0) begin                          // RULE7
          nxt_st.data  = i_adc_data;
          nxt_st.valid = 1'b1;
          nxt_st.kept  = 1;
        end
        if (st_ff.pulses == st_ff.req && !st_ff.tick_d) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy  = 1'b0;
          nxt_st.done  = 1'b1;
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase

    // analog output: n updates, done after n or n+1 pulses
    // the older engine needs pulse n+1 only to close the run; it updates nothing
    if (!st_ff.ao_run) begin
      if (i_ao_start) begin
        nxt_st.ao_run = i_ao_num_samples != '0;
        nxt_st.ao_num = i_ao_num_samples;
        nxt_st.ao_cnt = '0;
      end
    end else if (i_output_update_clock) begin
      nxt_st.ao_cnt = st_ff.ao_cnt + 1'b1;
      if (st_ff.ao_cnt < st_ff.ao_num) begin
        nxt_st.ao_upd = 1'b1;                                                 // RULE11
      end
      if (NEW_ENGINE ? (st_ff.ao_cnt + 1'b1 == st_ff.ao_num)                  // RULE12
                     : (st_ff.ao_cnt == st_ff.ao_num)) begin                  // RULE11
        nxt_st.ao_run = 1'b0;
      end
    end
    if (st_ff.ao_run && !nxt_st.ao_run) begin
      nxt_st.ao_done = 1'b1;
    end else if (i_ao_start) begin
      nxt_st.ao_done = 1'b0;
    end

    // non-buffered change detection straight to the outputs
    if (i_cd_enable && i_cd_buf_size == CNT_W'(BUF_SIZE_NONE)) begin         // RULE14
      nxt_st.cd_prev = i_ports;
      nxt_st.cd_out  = i_ports;                                               // RULE15
      if (FIRST_PORT_ONLY) begin
        nxt_st.cd_chg = i_ports[0] != st_ff.cd_prev[0];                       // RULE15
      end else begin
        nxt_st.cd_chg = i_ports != st_ff.cd_prev;                             // RULE14
      end
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff       <= '0;
      st_ff.state <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------------------
  assign o_sample_clk = st_ff.sclk;
  assign o_busy       = st_ff.busy;
  assign o_reject     = st_ff.reject;
  assign o_data       = st_ff.data;
  assign o_data_valid = st_ff.valid;
  assign o_acq_done   = st_ff.done;
  assign o_ao_update  = st_ff.ao_upd;
  assign o_ao_done    = st_ff.ao_done;
  assign o_cd_ports   = st_ff.cd_out;
  assign o_cd_change  = st_ff.cd_chg;
endmodule
`default_nettype wire

/* test/pasmt_checker.sv */
// concurrent checks on the sample timing block ports
`timescale 1ns/1ns
`default_nettype none
module pasmt_checker
  import pasmt_pkg::*;
(
  input  wire logic                             i_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_start,
  input  wire logic                             i_cd_enable,
  input  wire logic                             i_ao_start,
  input  wire logic                             i_output_update_clock,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] i_ports,
  input  wire logic                             o_busy,
  input  wire logic                             o_reject,
  input  wire logic                             o_data_valid,
  input  wire logic                             o_acq_done,
  input  wire logic                             o_ao_update,
  input  wire logic                             o_ao_done,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] o_cd_ports,
  input  wire logic                             o_cd_change
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ---------------------------------------------------------------------------
  // acquisition handshake
  // ---------------------------------------------------------------------------
  a_start_gets_answer: assert property (i_start && !o_busy |=> o_busy || o_reject)
    else $error("start not answered by busy or reject");
  a_reject_one_cycle: assert property (o_reject |=> !o_reject)
    else $error("reject longer than one cycle");
  a_reject_not_busy: assert property (o_reject |-> !o_busy)
    else $error("rejected request started running");
  a_valid_one_cycle: assert property (o_data_valid |=> !o_data_valid)
    else $error("data valid longer than one cycle");
  a_done_ends_busy: assert property (o_acq_done |=> !o_busy)
    else $error("busy still high after done");

  // ---------------------------------------------------------------------------
  // output generation and change detection
  // ---------------------------------------------------------------------------
  a_update_has_cause: assert property (o_ao_update |-> $past(i_output_update_clock))
    else $error("update without an output clock pulse");
  a_ao_done_holds: assert property (o_ao_done && !i_ao_start |=> o_ao_done)
    else $error("generation done dropped without a new start");
  a_cd_copy_match: assert property (o_cd_change |-> o_cd_ports == $past(i_ports))
    else $error("reported ports differ from sampled ports");
  a_cd_off_quiet: assert property (!$past(i_cd_enable) |-> !o_cd_change)
    else $error("change reported while detection disabled");
endmodule
bind pasmt_top pasmt_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
  .i_cd_enable(i_cd_enable), .i_ao_start(i_ao_start),
  .i_output_update_clock(i_output_update_clock), .i_ports(i_ports), .o_busy(o_busy),
  .o_reject(o_reject), .o_data_valid(o_data_valid), .o_acq_done(o_acq_done),
  .o_ao_update(o_ao_update), .o_ao_done(o_ao_done), .o_cd_ports(o_cd_ports),
  .o_cd_change(o_cd_change));
`default_nettype wire

/* test/pasmt_clk_source.sv */
// external sample clock source model feeding converter words
`timescale 1ns/1ns
`default_nettype none
module pasmt_clk_source
  import pasmt_pkg::*;
#(
  parameter logic [15:0] BASE = 16'ha500
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_go,
  input  wire logic [7:0]            i_count,
  input  wire logic [7:0]            i_gap,
  output logic                       o_tick,
  output logic [DATA_W_DEF-1:0]      o_data
);
  int left = 0;
  int wait_c = 0;
  int idx = 0;
  initial begin
    o_tick = 1'b0;
    o_data = '0;
  end
  // steady ticks at a fixed gap, the full count including flush pulses
  // word of a tick stands only in the following cycle, inverted otherwise
  always @(posedge i_clk) begin
    o_tick <= 1'b0;
    o_data <= o_tick ? DATA_W_DEF'(BASE + idx - 1) : ~o_data;
    if (i_go) begin
      left = i_count;
      idx = 0;
      wait_c = i_gap;
    end else if (left > 0) begin
      if (wait_c > 0) wait_c--;
      else begin
        o_tick <= 1'b1;
        idx++;
        left--;
        wait_c = i_gap;
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb_pipelined_adc_sample_timing.sv */
// self-checking bench for the pipelined adc sample timing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t %s", $time, m); end end
module tb_pipelined_adc_sample_timing
  import pasmt_pkg::*;
;
  localparam int PD = 3;
  logic i_clk = 0, i_rst = 1, i_start = 0, i_use_internal_clk = 0, i_scope_sel = 0;
  logic [1:0] i_mode = 0;
  logic [CNT_W-1:0] i_num_samples = 0, i_ao_num_samples = 0, i_cd_buf_size = 0;
  logic i_ao_start = 0, i_cd_enable = 0, ext_tick, ao_clk, src_go = 0, ao_go = 0;
  logic [7:0] src_cnt = 0, ao_cnt = 0;
  logic [DATA_W_DEF-1:0] adc_data, o_data;
  logic [NUM_PORTS-1:0][PORT_W-1:0] i_ports = '0, o_cd_ports;
  logic o_sample_clk, o_busy, o_reject, o_data_valid, o_acq_done, o_ao_update, o_ao_done;
  logic o_cd_change, clk_q = 0;
  logic use_src = 1, o2_sclk, o2_ao_done, o2_chg, q2 = 0;
  logic [DATA_W_DEF-1:0] word_cnt = 0, dut_word;
  int n2_clk = 0, n2_cd = 0;
  int num_errors = 0, total_checks = 0, n_clk = 0, n_valid = 0, n_upd = 0, n_cd = 0;
  logic [DATA_W_DEF-1:0] exp_q[$];

  always #4 i_clk = ~i_clk;

  pasmt_top #(.PIPE_DEPTH(PD)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
    .i_mode(i_mode), .i_num_samples(i_num_samples), .i_use_internal_clk(i_use_internal_clk),
    .i_scope_sel(i_scope_sel), .i_ext_tick(ext_tick), .i_adc_data(dut_word),
    .o_sample_clk(o_sample_clk), .o_busy(o_busy), .o_reject(o_reject), .o_data(o_data),
    .o_data_valid(o_data_valid), .o_acq_done(o_acq_done), .i_ao_start(i_ao_start),
    .i_ao_num_samples(i_ao_num_samples), .i_output_update_clock(ao_clk),
    .o_ao_update(o_ao_update), .o_ao_done(o_ao_done), .i_cd_enable(i_cd_enable),
    .i_cd_buf_size(i_cd_buf_size), .i_ports(i_ports), .o_cd_ports(o_cd_ports),
    .o_cd_change(o_cd_change));
  // converter words: from the outside source, or a running count on the internal clock
  assign dut_word = use_src ? adc_data : word_cnt;
  // second variant: no pipeline, newer output engine, changes watched on port 0 only
  pasmt_top #(.PIPE_DEPTH(PD), .PIPELINED(1'b0), .NEW_ENGINE(1'b1), .FIRST_PORT_ONLY(1'b1))
    DUT2 (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_mode(i_mode),
    .i_num_samples(i_num_samples), .i_use_internal_clk(i_use_internal_clk),
    .i_scope_sel(i_scope_sel), .i_ext_tick(ext_tick), .i_adc_data(dut_word),
    .o_sample_clk(o2_sclk), .o_busy(), .o_reject(), .o_data(), .o_data_valid(),
    .o_acq_done(), .i_ao_start(i_ao_start), .i_ao_num_samples(i_ao_num_samples),
    .i_output_update_clock(ao_clk), .o_ao_update(), .o_ao_done(o2_ao_done),
    .i_cd_enable(i_cd_enable), .i_cd_buf_size(i_cd_buf_size), .i_ports(i_ports),
    .o_cd_ports(), .o_cd_change(o2_chg));
  pasmt_clk_source u_src (.i_clk(i_clk), .i_go(src_go), .i_count(src_cnt), .i_gap(8'h03),
    .o_tick(ext_tick), .o_data(adc_data));
  pasmt_clk_source u_ao (.i_clk(i_clk), .i_go(ao_go), .i_count(ao_cnt), .i_gap(8'h02),
    .o_tick(ao_clk), .o_data());

  // ---------------------------------------------------------------------------
  // monitor: counts pulses and takes the oldest expected word per result
  // ---------------------------------------------------------------------------
  always @(posedge i_clk) begin
    clk_q <= o_sample_clk;
    q2 <= o2_sclk;
    word_cnt <= word_cnt + 16'h1;
    if (o_sample_clk && !clk_q) n_clk++;
    if (o2_sclk && !q2) n2_clk++;
    if (o_ao_update) n_upd++;
    if (o_cd_change) n_cd++;
    if (o2_chg) n2_cd++;
    if (o_data_valid) begin
      n_valid++;
      if (exp_q.size() > 0) `CHK(o_data, exp_q.pop_front(), "returned word")
      else `CHK(1'b1, 1'b0, "returned word not expected")
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic req(input logic [1:0] m, input logic sc, input int n, input logic intc);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_mode <= m;
    i_scope_sel <= sc;
    i_num_samples <= CNT_W'(n);
    i_use_internal_clk <= intc;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 2000 && o_acq_done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    `CHK(o_acq_done, 1'b1, "acquisition did not finish")
    cyc(4);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(60000);
    num_errors++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    int c0, v0, k, c2;
    logic [1:0] bad_m[3];
    logic bad_s[3];
    bad_m = '{MODE_CONTINUOUS, MODE_HW_SINGLE, MODE_ON_DEMAND};
    bad_s = '{1'b0, 1'b0, 1'b1};
    void'($urandom(32'h5315));
    cyc(8);
    i_rst <= 1'b0;
    cyc(2);
    // finite on external ticks: words aged by the depth, N plus depth pulses
    for (k = 0; k < 5; k++) exp_q.push_back(16'ha500 + 16'(k));
    c0 = n_clk;
    v0 = n_valid;
    req(MODE_FINITE, 1'b0, 5, 1'b0);
    `CHK(o_busy, 1'b1, "finite not started")
    src_go <= 1'b1;
    src_cnt <= 8'(5 + PD);
    cyc(1);
    src_go <= 1'b0;
    wait_done();
    `CHK(n_clk - c0, 5 + PD, "external pulse count")
    `CHK(n_valid - v0, 5, "finite word count")
    `CHK(exp_q.size(), 0, "words missing")
    $display("test finite external ended");
    use_src <= 1'b0;
    // finite on the internal clock, scope inputs: flush pulses made inside
    c0 = n_clk;
    v0 = n_valid;
    req(MODE_FINITE, 1'b1, 2, 1'b1);
    `CHK(o_busy, 1'b1, "scope finite refused")
    for (k = 1; k <= 2; k++) exp_q.push_back(word_cnt + 16'(k * RATE_DIV_DEF));
    wait_done();
    `CHK(n_clk - c0, 2 + PD, "internal pulse count")
    `CHK(n_valid - v0, 2, "internal word count")
    $display("test finite internal ended");
    // on-demand read: depth plus one pulses, one word kept
    c0 = n_clk;
    v0 = n_valid;
    c2 = n2_clk;
    req(MODE_ON_DEMAND, 1'b0, 0, 1'b1);
    exp_q.push_back(word_cnt + 16'(RATE_DIV_DEF));
    wait_done();
    `CHK(n_clk - c0, PD + 1, "burst pulse count")
    `CHK(n2_clk - c2, NONPIPE_PULSES, "unpipelined burst pulse count")
    `CHK(n_valid - v0, 1, "burst word count")
    $display("test on-demand ended");
    // illegal requests are refused
    for (k = 0; k < 3; k++) begin
      req(bad_m[k], bad_s[k], 4, 1'b1);
      `CHK(o_reject, 1'b1, "illegal mode accepted")
      `CHK(o_busy, 1'b0, "illegal mode running")
      cyc(2);
    end
    $display("test refusals ended");
    // finite generation: N updates, done after pulse N on the newer engine, only after pulse N plus one on the older
    @(posedge i_clk);
    i_ao_start <= 1'b1;
    i_ao_num_samples <= CNT_W'(3);
    ao_go <= 1'b1;
    ao_cnt <= 8'h03;
    @(posedge i_clk);
    i_ao_start <= 1'b0;
    ao_go <= 1'b0;
    cyc(20);
    `CHK(n_upd, 3, "update count")
    `CHK(o_ao_done, 1'b0, "done before extra pulse")
    `CHK(o2_ao_done, 1'b1, "newer engine not done after pulse N")
    ao_go <= 1'b1;
    ao_cnt <= 8'h01;
    cyc(1);
    ao_go <= 1'b0;
    cyc(8);
    `CHK(o_ao_done, 1'b1, "done missing after extra pulse")
    $display("test generation ended");
    // non-buffered change detection with random port values
    i_cd_enable <= 1'b1;
    for (k = 0; k < 4; k++) begin
      v0 = n_cd;
      i_ports <= i_ports ^ 24'($urandom | 1);
      cyc(4);
      `CHK(n_cd - v0, 1, "change not reported")
      `CHK(o_cd_ports, i_ports, "reported ports")
    end
    v0 = n_cd;
    c2 = n2_cd;
    i_ports[1] <= ~i_ports[1];
    cyc(4);
    `CHK(n_cd - v0, 1, "port 1 change not reported")
    `CHK(n2_cd - c2, 0, "port 1 change seen on first-port variant")
    i_cd_enable <= 1'b0;
    v0 = n_cd;
    cyc(1);
    i_ports <= ~i_ports;
    cyc(4);
    `CHK(n_cd - v0, 0, "change while disabled")
    $display("test change detection ended");
    complete_run();
  end
endmodule
`default_nettype wire
